/* File: logic/codec_serial_power_config_regs.sv */
`default_nettype none
module codec_serial_power_config_regs (
	input wire logic i_mclk, // Master clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_ce, // Clock enable
	input wire logic i_wr_en, // Register write strobe
	input wire logic i_rd_en, // Register read strobe
	input wire logic [2:0] i_sel, // Register select
	input wire logic [7:0] i_wr_data, // Write data
	output logic [7:0] o_rd_data, // Read data
	input wire logic [3:0] i_cascade_addr, // Cascade device address
	input wire logic [4:0] i_device_count, // Cascaded devices, 1 to 16
	input wire logic [1:0] i_mode_factor, // Mode factor
	input wire logic i_serial_master, // Device is serial master
	input wire logic [6:0] i_div_m, // M code, 0 means 128
	input wire logic [3:0] i_div_n, // N code, 0 means 16
	input wire logic [2:0] i_div_p, // P code, 0 means 8
	input wire logic i_scl_pin, // Clock pin level
	input wire logic i_host_sda_low, // Host port pulls data pin low
	input wire logic i_ctrl_frame_flag, // Control frame flag
	output logic o_sda_out, // Data pin drive value
	output logic o_sda_oe_n, // Data pin enable, low drives
	output logic o_dout, // Serial data output pass level
	output logic o_dout_pass, // Data output shows clock pin
	output logic o_i2c_sel, // Pins run as I2C
	output logic o_simple_serial_control, // Pins run as simple serial
	output logic [6:0] o_host_address, // Host port bus address
	output logic o_filter_bypass, // Filters bypassed
	output logic o_adc_power_down, // ADC powered down
	output logic o_dac_power_down, // DAC powered down
	output logic o_device_power_down, // Whole device down
	output logic [9:0] o_dac_osr, // DAC oversampling ratio
	output logic o_turbo, // Fast bit clock selected
	output logic o_bclk_tick, // Fast bit clock enable pulse
	output logic [11:0] o_bclk_per_frame, // Normal bit clocks per frame
	output logic o_frame_tick, // Frame rate pulse
	output logic o_sample_tick, // Sampling rate pulse
	output logic o_soft_reset // Software reset pulse
);
	import codec_cfg_pkg::*;

	// Divider code to value, zero code meaning the top value
	function automatic logic [7:0] div_value(input logic [6:0] code, input logic [7:0] top);
		div_value = (code == 7'h00) ? top : {1'b0, code};
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	serial_host_config_t sh_reg, sh_next; // Serial and host setup
	power_rate_config_t pr_reg, pr_next; // Power and rate setup
	logic [7:0] rd_reg, rd_next; // Read data
	logic srst_reg, srst_next; // Soft reset pulse
	logic scl_s1_reg, scl_s2_reg; // Clock pin synchroniser
	logic sda_out_reg, sda_out_next; // Data pin value
	logic sda_oe_n_reg, sda_oe_n_next; // Data pin enable
	logic dout_reg, dout_next; // Passed clock pin level
	logic [FRAME_W-1:0] frame_cnt_reg, frame_cnt_next; // Frame divider
	logic [2:0] ratio_cnt_reg, ratio_cnt_next; // Frames per sample
	logic [2:0] p_cnt_reg, p_cnt_next; // Fast bit clock divider
	logic frame_reg, frame_next, sample_reg, sample_next, bclk_reg, bclk_next;
	logic [7:0] m_val, n_val, p_val; // Decoded dividers
	logic [FRAME_W-1:0] frame_period; // Master clocks per frame
	logic [3:0] ratio_val; // Frames per sample

	// Divider decode
	always_comb
	begin
		m_val = div_value(i_div_m, 8'h80);
		n_val = div_value({3'h0, i_div_n}, 8'h10);
		p_val = div_value({4'h0, i_div_p}, 8'h08);
		frame_period = FRAME_W'(BITS_PER_SLOT)
			* FRAME_W'(m_val) * FRAME_W'(n_val) * FRAME_W'(p_val);
		ratio_val = (pr_reg.sample_rate_ratio == 3'h0) ? 4'h8
			: {1'b0, pr_reg.sample_rate_ratio};
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	// Writes, reads and software reset
	always_comb
	begin
		sh_next = sh_reg;
		pr_next = pr_reg;
		rd_next = rd_reg;
		srst_next = 1'b0;
		if (srst_reg)
		begin
			// Every field back to its reset value
			sh_next = SERIAL_HOST_RESET;
			pr_next = POWER_RATE_RESET;
		end
		else if (i_wr_en && i_sel == SEL_SERIAL_HOST)
			sh_next = serial_host_config_t'(i_wr_data);
		else if (i_wr_en && i_sel == SEL_POWER_RATE)
		begin
			pr_next = power_rate_config_t'(i_wr_data);
			srst_next = pr_next.soft_reset_bit;
		end
		if (i_rd_en)
		begin
			// Unselected registers read as zero
			unique case (i_sel)
				SEL_SERIAL_HOST: rd_next = sh_reg;
				SEL_POWER_RATE: rd_next = pr_reg;
				default: rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sh_reg <= SERIAL_HOST_RESET;
			pr_reg <= POWER_RATE_RESET;
			rd_reg <= 8'h00;
			srst_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			sh_reg <= sh_next;
			pr_reg <= pr_next;
			rd_reg <= rd_next;
			srst_reg <= srst_next;
		end
	end

	// ****************************************************************
	// Host pins
	// ****************************************************************
	// Clock pin synchroniser
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			scl_s1_reg <= 1'b0;
			scl_s2_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			scl_s1_reg <= i_scl_pin;
			scl_s2_reg <= scl_s1_reg;
		end
	end

	// Data pin function by pin mode
	always_comb
	begin
		sda_out_next = 1'b0;
		sda_oe_n_next = 1'b1;
		dout_next = 1'b0;
		unique case (sh_reg.host_pin_config)
			HPC_I2C, HPC_SIMPLE:
				sda_oe_n_next = !i_host_sda_low; // Open drain from host port
			HPC_GPO:
			begin
				sda_out_next = sh_reg.general_output_bit;
				sda_oe_n_next = 1'b0;
				dout_next = scl_s2_reg;
			end
			HPC_FLAG:
			begin
				sda_out_next = i_ctrl_frame_flag;
				sda_oe_n_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sda_out_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
			dout_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			sda_out_reg <= sda_out_next;
			sda_oe_n_reg <= sda_oe_n_next;
			dout_reg <= dout_next;
		end
	end

	// ****************************************************************
	// Frame, sample and bit clock timing
	// ****************************************************************
	// Dividers
	always_comb
	begin
		frame_cnt_next = frame_cnt_reg + FRAME_W'(1);
		frame_next = 1'b0;
		ratio_cnt_next = ratio_cnt_reg;
		sample_next = 1'b0;
		p_cnt_next = p_cnt_reg + 3'h1;
		bclk_next = 1'b0;
		if (frame_cnt_reg >= frame_period - FRAME_W'(1))
		begin
			// Frame boundary
			frame_cnt_next = '0;
			frame_next = 1'b1;
			ratio_cnt_next = ratio_cnt_reg + 3'h1;
			if ({1'b0, ratio_cnt_reg} >= ratio_val - 4'h1)
			begin
				ratio_cnt_next = 3'h0; // One sample per n frames
				sample_next = 1'b1;
			end
		end
		if ({5'h00, p_cnt_reg} >= p_val - 8'h01)
		begin
			// Master clock over P, master only
			p_cnt_next = 3'h0;
			bclk_next = sh_reg.turbo && i_serial_master;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			frame_cnt_reg <= '0;
			ratio_cnt_reg <= 3'h0;
			p_cnt_reg <= 3'h0;
			frame_reg <= 1'b0;
			sample_reg <= 1'b0;
			bclk_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			frame_cnt_reg <= frame_cnt_next;
			ratio_cnt_reg <= ratio_cnt_next;
			p_cnt_reg <= p_cnt_next;
			frame_reg <= frame_next;
			sample_reg <= sample_next;
			bclk_reg <= bclk_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_rd_data = rd_reg;
	assign o_soft_reset = srst_reg;
	assign o_sda_out = sda_out_reg;
	assign o_sda_oe_n = sda_oe_n_reg;
	assign o_dout = dout_reg;
	assign o_dout_pass = (sh_reg.host_pin_config == HPC_GPO);
	assign o_i2c_sel = (sh_reg.host_pin_config == HPC_I2C);
	assign o_simple_serial_control = (sh_reg.host_pin_config == HPC_SIMPLE);
	assign o_host_address = {sh_reg.host_address_high_bits, i_cascade_addr};
	assign o_filter_bypass = sh_reg.filter_bypass;
	assign o_adc_power_down = (pr_reg.power_down_select == POWER_DOWN_SELECT_ADC)
		|| (pr_reg.power_down_select == POWER_DOWN_SELECT_ALL);
	assign o_dac_power_down = (pr_reg.power_down_select == POWER_DOWN_SELECT_DAC)
		|| (pr_reg.power_down_select == POWER_DOWN_SELECT_ALL);
	assign o_device_power_down = (pr_reg.power_down_select == POWER_DOWN_SELECT_ALL);
	assign o_dac_osr = pr_reg.dac_oversampling_select[0] ? OSR_512
		: (pr_reg.dac_oversampling_select[1] ? OSR_256 : OSR_128);
	assign o_turbo = sh_reg.turbo;
	assign o_bclk_tick = bclk_reg;
	assign o_bclk_per_frame = 12'(BITS_PER_SLOT) * 12'(i_device_count) * 12'(i_mode_factor);
	assign o_frame_tick = frame_reg;
	assign o_sample_tick = sample_reg;
endmodule
`default_nettype wire

/* File: inc/codec_cfg_pkg.sv */
`default_nettype none
package codec_cfg_pkg;
	// ****************************************************************
	// Register selects on the host port
	// ****************************************************************
	localparam logic [2:0] SEL_SERIAL_HOST = 3'h2; // Serial and host setup
	localparam logic [2:0] SEL_POWER_RATE = 3'h3; // Power and rate setup

	// ****************************************************************
	// Field layouts
	// ****************************************************************
	typedef struct packed {
		logic turbo; // Fast bit clock select
		logic filter_bypass; // Filter bypass
		logic [2:0] host_address_high_bits; // Address high bits
		logic general_output_bit; // General purpose output
		logic [1:0] host_pin_config; // Host pin function
	} serial_host_config_t;

	typedef struct packed {
		logic [1:0] power_down_select; // Power state
		logic soft_reset_bit; // Software reset request
		logic [1:0] dac_oversampling_select; // DAC oversampling
		logic [2:0] sample_rate_ratio; // Frames per sample
	} power_rate_config_t;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam serial_host_config_t SERIAL_HOST_RESET = 8'h20;
	localparam power_rate_config_t POWER_RATE_RESET = 8'h01;

	// ****************************************************************
	// Field encodings and counts
	// ****************************************************************
	localparam logic [1:0] HPC_I2C = 2'h0; // Pins form I2C port
	localparam logic [1:0] HPC_SIMPLE = 2'h1; // Pins form simple serial port
	localparam logic [1:0] HPC_GPO = 2'h2; // Data pin shows output bit
	localparam logic [1:0] HPC_FLAG = 2'h3; // Data pin shows frame flag
	localparam logic [1:0] POWER_DOWN_SELECT_ADC = 2'h1; // ADC off
	localparam logic [1:0] POWER_DOWN_SELECT_DAC = 2'h2; // DAC off
	localparam logic [1:0] POWER_DOWN_SELECT_ALL = 2'h3; // Whole device off
	localparam logic [9:0] OSR_512 = 10'h200;
	localparam logic [9:0] OSR_256 = 10'h100;
	localparam logic [9:0] OSR_128 = 10'h080;
	localparam logic [4:0] BITS_PER_SLOT = 5'h10; // Bit clocks per device slot
	localparam int FRAME_W = 19; // Width of 16 x M x N x P
endpackage
`default_nettype wire

/* File: test/codec_serial_power_config_regs_chk.sv */
`default_nettype none
module codec_serial_power_config_regs_chk
	import codec_cfg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wr_en,
	input wire logic [2:0] i_sel,
	input wire logic [7:0] i_wr_data,
	input wire logic [3:0] i_cascade_addr,
	input wire logic i_serial_master,
	input wire logic i_scl_pin,
	input wire logic i_host_sda_low,
	input wire logic i_ctrl_frame_flag,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic o_dout,
	input wire logic o_dout_pass,
	input wire logic o_i2c_sel,
	input wire logic o_simple_serial_control,
	input wire logic [6:0] o_host_address,
	input wire logic o_filter_bypass,
	input wire logic [9:0] o_dac_osr,
	input wire logic o_turbo,
	input wire logic o_bclk_tick,
	input wire logic o_soft_reset
);
	// One clock domain, reset disables all
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_addr_concat: assert property (o_host_address[3:0] == i_cascade_addr)
		else $error("host address low bits differ from cascade address");
	a_host_write: assert property (
		i_ce && i_wr_en && i_sel == SEL_SERIAL_HOST && !o_soft_reset |=>
		o_filter_bypass == $past(i_wr_data[6]) && o_turbo == $past(i_wr_data[7])
		&& o_host_address[6:4] == $past(i_wr_data[5:3])
		&& o_i2c_sel == ($past(i_wr_data[1:0]) == HPC_I2C)
		&& o_dout_pass == ($past(i_wr_data[1:0]) == HPC_GPO))
		else $error("serial host fields wrong after write");
	a_rate_write: assert property (
		i_ce && i_wr_en && i_sel == SEL_POWER_RATE && !i_wr_data[5] && !o_soft_reset |=>
		o_dac_osr == ($past(i_wr_data[3]) ? OSR_512 : $past(i_wr_data[4]) ? OSR_256 : OSR_128))
		else $error("oversampling ratio wrong after write");
	a_soft_pulse: assert property (
		i_ce && i_wr_en && i_sel == SEL_POWER_RATE && i_wr_data[5] && !o_soft_reset |=>
		o_soft_reset ##1 (!o_soft_reset && o_host_address[6:4] == 3'h4
		&& o_dac_osr == OSR_128 && o_i2c_sel))
		else $error("soft reset pulse or restore wrong");
	a_flag_drive: assert property (
		!o_i2c_sel && !o_simple_serial_control && !o_dout_pass
		&& $past(!o_i2c_sel && !o_simple_serial_control && !o_dout_pass)
		|-> !o_sda_oe_n && o_sda_out == $past(i_ctrl_frame_flag))
		else $error("data pin does not show frame flag");
	a_dout_lag: assert property (
		o_dout_pass && $past(o_dout_pass) && $past(o_dout_pass, 4)
		|-> o_dout == $past(i_scl_pin, 3))
		else $error("data output does not follow clock pin");
	a_bclk_gate: assert property (o_bclk_tick |-> $past(o_turbo && i_serial_master))
		else $error("fast bit clock tick outside turbo master");
	a_i2c_drain: assert property (
		o_i2c_sel && $past(o_i2c_sel) && $past(i_rst_n)
		|-> o_sda_oe_n == !$past(i_host_sda_low) && !o_sda_out)
		else $error("open drain data pin wrong in I2C mode");
endmodule
bind codec_serial_power_config_regs codec_serial_power_config_regs_chk u_chk (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_ce(i_ce),
	.i_wr_en(i_wr_en),
	.i_sel(i_sel),
	.i_wr_data(i_wr_data),
	.i_cascade_addr(i_cascade_addr),
	.i_serial_master(i_serial_master),
	.i_scl_pin(i_scl_pin),
	.i_host_sda_low(i_host_sda_low),
	.i_ctrl_frame_flag(i_ctrl_frame_flag),
	.o_sda_out(o_sda_out),
	.o_sda_oe_n(o_sda_oe_n),
	.o_dout(o_dout),
	.o_dout_pass(o_dout_pass),
	.o_i2c_sel(o_i2c_sel),
	.o_simple_serial_control(o_simple_serial_control),
	.o_host_address(o_host_address),
	.o_filter_bypass(o_filter_bypass),
	.o_dac_osr(o_dac_osr),
	.o_turbo(o_turbo),
	.o_bclk_tick(o_bclk_tick),
	.o_soft_reset(o_soft_reset)
);
`default_nettype wire

/* File: test/host_pins_model.sv */
`default_nettype none
module host_pins_model
(
	input wire logic i_mclk,
	output logic o_scl,
	output logic o_sda_low,
	output logic o_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00; // Pattern source for host pins
	// Pins move just after each rising edge
	always
	begin
		@(posedge i_mclk);
		#1;
		cnt = cnt + 8'h01;
	end
	assign o_scl = cnt[1] ^ cnt[4];
	assign o_sda_low = cnt[0] & cnt[2];
	assign o_flag = cnt[3];
endmodule
`default_nettype wire

/* File: test/test_codec_serial_power_config_regs.sv */
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_codec_serial_power_config_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import codec_cfg_pkg::*;
	logic i_mclk = 0, i_rst_n = 0, i_ce = 1, i_wr_en = 0, i_rd_en = 0, i_serial_master = 1;
	logic [2:0] i_sel = 0, i_div_p = 1;
	logic [7:0] i_wr_data = 0, o_rd_data;
	logic [3:0] i_cascade_addr = 0, i_div_n = 1;
	logic [4:0] i_device_count = 1;
	logic [1:0] i_mode_factor = 1;
	logic [6:0] i_div_m = 1, o_host_address;
	logic i_scl_pin, i_host_sda_low, i_ctrl_frame_flag, o_sda_out, o_sda_oe_n, o_dout, o_turbo;
	logic o_dout_pass, o_i2c_sel, o_simple_serial_control, o_filter_bypass, o_adc_power_down;
	logic o_dac_power_down, o_device_power_down, o_bclk_tick, o_frame_tick, o_sample_tick;
	logic o_soft_reset;
	logic [9:0] o_dac_osr;
	logic [11:0] o_bclk_per_frame;
	serial_host_config_t sh = SERIAL_HOST_RESET; // Model of first register
	power_rate_config_t pr = POWER_RATE_RESET; // Model of second register
	logic [31:0] rs = 32'h00000033, r;
	int err_count = 0, cmp_count = 0, n, p;
	codec_serial_power_config_regs dut (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en),
		.i_sel(i_sel),
		.i_wr_data(i_wr_data),
		.o_rd_data(o_rd_data),
		.i_cascade_addr(i_cascade_addr),
		.i_device_count(i_device_count),
		.i_mode_factor(i_mode_factor),
		.i_serial_master(i_serial_master),
		.i_div_m(i_div_m),
		.i_div_n(i_div_n),
		.i_div_p(i_div_p),
		.i_scl_pin(i_scl_pin),
		.i_host_sda_low(i_host_sda_low),
		.i_ctrl_frame_flag(i_ctrl_frame_flag),
		.o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n),
		.o_dout(o_dout),
		.o_dout_pass(o_dout_pass),
		.o_i2c_sel(o_i2c_sel),
		.o_simple_serial_control(o_simple_serial_control),
		.o_host_address(o_host_address),
		.o_filter_bypass(o_filter_bypass),
		.o_adc_power_down(o_adc_power_down),
		.o_dac_power_down(o_dac_power_down),
		.o_device_power_down(o_device_power_down),
		.o_dac_osr(o_dac_osr),
		.o_turbo(o_turbo),
		.o_bclk_tick(o_bclk_tick),
		.o_bclk_per_frame(o_bclk_per_frame),
		.o_frame_tick(o_frame_tick),
		.o_sample_tick(o_sample_tick),
		.o_soft_reset(o_soft_reset)
	);
	host_pins_model u_host (.i_mclk(i_mclk), .o_scl(i_scl_pin), .o_sda_low(i_host_sda_low),
		.o_flag(i_ctrl_frame_flag));
	always #20 i_mclk = ~i_mclk;
	function automatic logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Next cycle, inputs move 1 ns after the edge
	task tick();
		@(posedge i_mclk);
		#1;
	endtask
	task wr(input logic [2:0] s, input logic [7:0] d);
		i_wr_en = 1;
		i_sel = s;
		i_wr_data = d;
		tick();
		i_wr_en = 0;
		if (s == SEL_SERIAL_HOST) sh = d;
		if (s == SEL_POWER_RATE) pr = d;
		if (s == SEL_POWER_RATE && d[5])
		begin
			sh = SERIAL_HOST_RESET;
			pr = POWER_RATE_RESET;
		end
		tick();
	endtask
	task rd(input logic [2:0] s);
		i_rd_en = 1;
		i_sel = s;
		tick();
		i_rd_en = 0;
		`CHK("read", s == SEL_SERIAL_HOST ? sh : s == SEL_POWER_RATE ? pr : 8'h00, o_rd_data);
		tick();
	endtask
	// Compare register-driven outputs with the model, ADC and DAC power down only when not all off
	task fields();
		`CHK("bypass", sh.filter_bypass, o_filter_bypass);
		`CHK("turbo", sh.turbo, o_turbo);
		`CHK("addr", {sh.host_address_high_bits, i_cascade_addr}, o_host_address);
		`CHK("i2c", sh.host_pin_config == HPC_I2C, o_i2c_sel);
		`CHK("simple", sh.host_pin_config == HPC_SIMPLE, o_simple_serial_control);
		`CHK("pass", sh.host_pin_config == HPC_GPO, o_dout_pass);
		`CHK("off", pr.power_down_select == POWER_DOWN_SELECT_ALL, o_device_power_down);
		if (pr.power_down_select != POWER_DOWN_SELECT_ALL)
		begin
			`CHK("adc", pr.power_down_select == POWER_DOWN_SELECT_ADC, o_adc_power_down);
			`CHK("dac", pr.power_down_select == POWER_DOWN_SELECT_DAC, o_dac_power_down);
		end
		`CHK("osr", pr.dac_oversampling_select[0] ? OSR_512 : pr.dac_oversampling_select[1] ?
			OSR_256 : OSR_128, o_dac_osr);
		`CHK("slot", 12'(16 * i_device_count * i_mode_factor), o_bclk_per_frame);
		if (sh.host_pin_config == HPC_GPO)
		begin
			`CHK("gpo", {1'b0, sh.general_output_bit}, {o_sda_oe_n, o_sda_out});
		end
	endtask
	// Cycles between two pulses of a tick output
	task gap(input int w, output int c);
		c = 0;
		while (!(w == 0 ? o_frame_tick : w == 1 ? o_sample_tick : o_bclk_tick) && c < 5000)
		begin
			tick();
			c++;
		end
		c = 0;
		do
		begin
			tick();
			c++;
		end while (!(w == 0 ? o_frame_tick : w == 1 ? o_sample_tick : o_bclk_tick) && c < 5000);
	endtask
	task close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#2000000;
		err_count++;
		close_out();
	end
	initial
	begin
		repeat (20) tick();
		i_rst_n = 1;
		fields();
		wr(3'h4, 8'hFF);
		rd(SEL_SERIAL_HOST);
		rd(SEL_POWER_RATE);
		rd(3'h4);
		// All pin, power and oversampling codes with random other bits
		for (int i = 0; i < 16; i++)
		begin
			r = nxt();
			i_cascade_addr = r[3:0];
			i_device_count = {1'b0, r[11:8]} + 5'h01;
			i_mode_factor = r[13:12];
			wr(SEL_SERIAL_HOST, {r[23:18], 2'(i)});
			wr(SEL_POWER_RATE, {2'(i), 1'b0, 2'(i >> 2), r[2:0]});
			rd(SEL_SERIAL_HOST);
			rd(SEL_POWER_RATE);
			fields();
		end
		// Soft reset, then a write in the next cycle that must be lost
		i_wr_en = 1;
		i_sel = SEL_POWER_RATE;
		i_wr_data = 8'h20;
		tick();
		`CHK("pulse", 1'b1, o_soft_reset);
		i_sel = SEL_SERIAL_HOST;
		i_wr_data = 8'hFF;
		tick();
		i_wr_en = 0;
		sh = SERIAL_HOST_RESET;
		pr = POWER_RATE_RESET;
		rd(SEL_SERIAL_HOST);
		rd(SEL_POWER_RATE);
		fields();
		r = nxt();
		i_div_p = {1'b0, r[1:0]} + 3'h1;
		p = int'(i_div_p);
		wr(SEL_POWER_RATE, 8'h03);
		gap(0, n);
		`CHK("frame", 16 * p, n);
		gap(1, n);
		gap(1, n);
		`CHK("sample", 48 * p, n);
		wr(SEL_POWER_RATE, 8'h00);
		gap(1, n);
		gap(1, n);
		`CHK("sample8", 128 * p, n);
		wr(SEL_SERIAL_HOST, 8'h83);
		gap(2, n);
		`CHK("bclk", p, n);
		i_serial_master = 0;
		tick();
		// Fast bit clock must stay quiet once the device is no longer master
		repeat (8)
		begin
			tick();
			`CHK("bclk_off", 1'b0, o_bclk_tick);
		end
		repeat (10) tick();
		close_out();
	end
endmodule
`default_nettype wire
